/* verilog/tbds_timebase.sv */
// timebase divider and trigger synchronizer, top level
// assumes mclk plays the sample clock; divided clocks are levels built
// from enable-driven counters, system_trigger_in is fully asynchronous
//
// Function
// - The 1 GHz and 250 MHz clocks come from the sample clock by division.
// - Each digitizer clock is gated by the run gate so all start together.
// - The trigger is aligned to the 1 GHz clock and gives two phase bits.
// - The quarter-rate clock is the 1 GHz timebase clock divided by four.
// - Four quarter-rate outputs are spaced a quarter period apart in phase.
// - The calibrator quarter-rate clock is switched off while it idles.
// - The asynchronous trigger passes a two-stage synchronizer.
// - Each trigger rise gives exactly one timebase trigger pulse, promptly.
// - Each trigger rise gives exactly one pulse on the quarter-rate clock.
// - Gate and trigger phase to the quarter clock may be any, but is fixed.
// - The quarter-rate to timebase trigger phase is output as a 2-bit code.
// - Phase bit 0 comes from the 500 MHz clock, bit 1 from the 250 MHz one.
`timescale 1ns/10ps
`default_nettype none
`include "tbds_params.svh"

module tbds_timebase
    import tbds_pkg::*;
#(
    parameter int NUM_DIG = `TBDS_NUM_DIG
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic system_trigger_in,
    input wire logic digitizer_run_gate,
    input wire logic cal_clock_enable,
    output logic [NUM_DIG-1:0] digitizer_clock,
    output logic timebase_clock,
    output logic [`TBDS_NUM_QR-1:0] quarter_rate_clock,
    output logic cal_quarter_rate_clock,
    output tbds_trig_t trig
);

    // ----------------------------------------------------------------
    // dividers
    // ----------------------------------------------------------------
    wire logic tb_tick;
    wire logic qr_tick;
    wire logic [`TBDS_TB_CNT_W-1:0] tb_count;
    wire logic [`TBDS_QR_CNT_W-1:0] qr_count;

    // both counters clear together under reset, so phases are common
    tbds_divider #(
        .N(`TBDS_SAMPLE_DIV),
        .W(`TBDS_TB_CNT_W)
    ) u_tb_div (
        .mclk(mclk),
        .nrst(nrst),
        .en(1'b1),
        .tick(tb_tick),
        .count(tb_count)
    );

    tbds_divider #(
        .N(`TBDS_QUARTER_DIV),
        .W(`TBDS_QR_CNT_W)
    ) u_qr_div (
        .mclk(mclk),
        .nrst(nrst),
        .en(tb_tick),
        .tick(qr_tick),
        .count(qr_count)
    );

    // ----------------------------------------------------------------
    // clock levels
    // ----------------------------------------------------------------
    wire logic next_tb_level;
    wire logic [`TBDS_NUM_QR-1:0] next_qr_level;
    wire logic next_cal_clk;
    logic run_q;
    logic cal_en_q;

    // high for the first half of each timebase period
    assign next_tb_level = (tb_count < `TBDS_TB_CNT_W'(`TBDS_SAMPLE_DIV / 2));

    // phase k is high while (count - k) mod 4 is 0 or 1
    genvar gi;
    generate
        for (gi = 0; gi < `TBDS_NUM_QR; gi++) begin : g_qr
            wire logic [`TBDS_QR_CNT_W-1:0] qdiff;
            assign qdiff = qr_count - `TBDS_QR_CNT_W'(gi);
            assign next_qr_level[gi] = ~qdiff[1];
        end
    endgenerate

    assign next_cal_clk = next_qr_level[0] & cal_en_q;

    // run gate and calibrator enable change only on period boundaries,
    // which keeps every gated clock free of runt pulses
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            run_q <= 1'b0;
        end else if (tb_tick) begin
            run_q <= digitizer_run_gate;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cal_en_q <= 1'b0;
        end else if (qr_tick) begin
            cal_en_q <= cal_clock_enable;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            timebase_clock <= 1'b0;
            digitizer_clock <= '0;
            quarter_rate_clock <= '0;
            cal_quarter_rate_clock <= 1'b0;
        end else begin
            timebase_clock <= next_tb_level;
            digitizer_clock <= {NUM_DIG{next_tb_level & run_q}};
            quarter_rate_clock <= next_qr_level;
            cal_quarter_rate_clock <= next_cal_clk;
        end
    end

    // ----------------------------------------------------------------
    // trigger synchronizer and pulse generation
    // ----------------------------------------------------------------
    logic sync1;
    logic sync2;
    logic sync3;
    logic tb_pend;
    logic qr_pend;
    wire logic trig_rise;
    wire logic tb_fire;
    wire logic qr_fire;
    wire logic [1:0] next_phase;

    // sync1 feeds sync2 only; edge detect looks at sync2/sync3
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= system_trigger_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign trig_rise = sync2 & ~sync3;
    // fire on the next timebase / quarter boundary; a rise arriving on
    // the boundary itself fires at once instead of waiting a period
    assign tb_fire = tb_tick & (tb_pend | trig_rise);
    assign qr_fire = qr_tick & (qr_pend | trig_rise);
    // bit 0 tracks the 500 MHz divided clock, bit 1 the 250 MHz clock
    assign next_phase = {qr_count[1], qr_count[0]};

    // clear wins over set: a rise on the fire cycle is absorbed by it
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tb_pend <= 1'b0;
            qr_pend <= 1'b0;
        end else begin
            tb_pend <= (tb_pend | trig_rise) & ~tb_tick;
            qr_pend <= (qr_pend | trig_rise) & ~qr_tick;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            trig <= '0;
        end else begin
            trig.timebase_trigger_pulse <= tb_fire;
            trig.quarter_rate_trigger_pulse <= qr_fire;
            if (tb_fire) begin
                trig.phase_code <= next_phase;
            end
        end
    end

    // limitation: two rises closer than one quarter period merge into
    // one quarter-rate pulse; the trigger system never spaces them so

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_tb_period: assert property (
        @(posedge mclk) disable iff (!nrst)
        tb_tick |-> ##10 tb_tick
    ) else $error("timebase divider period is not ten cycles");

    a_qr_period: assert property (
        @(posedge mclk) disable iff (!nrst)
        qr_tick |-> ##40 qr_tick
    ) else $error("quarter-rate period is not four timebase periods");

    a_dig_gated: assert property (
        @(posedge mclk) disable iff (!nrst)
        !run_q |=> digitizer_clock == '0
    ) else $error("digitizer clock runs with the gate closed");

    a_cal_off: assert property (
        @(posedge mclk) disable iff (!nrst)
        (!cal_clock_enable && qr_tick) |=> ##1 !cal_quarter_rate_clock [*8]
    ) else $error("calibrator clock runs while disabled");

    a_qr_quadrature: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(quarter_rate_clock[0]) |-> ##10 $rose(quarter_rate_clock[1])
    ) else $error("quarter-rate phases not a quarter period apart");

    a_tb_prompt: assert property (
        @(posedge mclk) disable iff (!nrst)
        trig_rise |-> ##[1:10] trig.timebase_trigger_pulse
    ) else $error("timebase trigger pulse missing after rise");

    a_tb_single: assert property (
        @(posedge mclk) disable iff (!nrst)
        trig.timebase_trigger_pulse |=> !trig.timebase_trigger_pulse [*8]
    ) else $error("timebase trigger pulse repeated");

    a_qr_prompt: assert property (
        @(posedge mclk) disable iff (!nrst)
        trig_rise |-> ##[1:40] trig.quarter_rate_trigger_pulse
    ) else $error("quarter-rate trigger pulse missing after rise");

    a_qr_aligned: assert property (
        @(posedge mclk) disable iff (!nrst)
        trig.quarter_rate_trigger_pulse |-> $past(qr_tick)
    ) else $error("quarter-rate pulse off the quarter boundary");

    a_phase_code: assert property (
        @(posedge mclk) disable iff (!nrst)
        trig.timebase_trigger_pulse |-> trig.phase_code == $past(qr_count)
    ) else $error("phase code not the divider phase at the trigger");

    a_sync_delay: assert property (
        @(posedge mclk) disable iff (!nrst)
        trig_rise |-> $past(system_trigger_in, 2) && !$past(sync2)
    ) else $error("trigger rise seen without two synchronizer stages");

    a_reset_quiet: assert property (
        @(posedge mclk)
        !nrst |=> !trig.timebase_trigger_pulse && tb_count == '0
    ) else $error("reset did not clear pulses and divider");

endmodule

`default_nettype wire

/* verilog/tbds_params.svh */
// timing and sizing constants for the timebase divider / trigger sync
// assumes mclk stands in for the sample clock; all rates are enables
`ifndef TBDS_PARAMS_SVH
`define TBDS_PARAMS_SVH

// ----------------------------------------------------------------
// clock rates
// ----------------------------------------------------------------
`define TBDS_SAMPLE_HZ 10000000000.0
`define TBDS_TIMEBASE_HZ 1000000000.0
`define TBDS_QUARTER_HZ 250000000.0
`define TBDS_MCLK_PERIOD_NS 50

// ----------------------------------------------------------------
// division ratios and counter widths
// ----------------------------------------------------------------
`define TBDS_SAMPLE_DIV 10
`define TBDS_QUARTER_DIV 4
`define TBDS_TB_CNT_W 4
`define TBDS_QR_CNT_W 2
`define TBDS_NUM_DIG 4
`define TBDS_NUM_QR 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TBDS_TB_CNT_RST 4'h0
`define TBDS_QR_CNT_RST 2'h0
`define TBDS_PHASE_RST 2'h0

`endif

/* verilog/tbds_pkg.sv */
// types shared by the timebase divider and trigger sync
// assumes tbds_params.svh is on the include path
`default_nettype none
`include "tbds_params.svh"

package tbds_pkg;

    // trigger results, all registered in the mclk domain
    typedef struct packed {
        logic timebase_trigger_pulse;
        logic quarter_rate_trigger_pulse;
        logic [1:0] phase_code;
    } tbds_trig_t;

endpackage

`default_nettype wire

/* verilog/tbds_divider.sv */
// modulo-n counter: advances on en, ticks on the last count
// assumes a single clock mclk with synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module tbds_divider #(
    parameter int N = 10,
    parameter int W = 4
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic en,
    output logic tick,
    output logic [W-1:0] count
);

    wire logic at_last;

    assign at_last = (count == W'(N - 1));
    // tick is a handshake-style enable, combinational on purpose
    assign tick = en & at_last;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            count <= '0;
        end else if (tick) begin
            count <= '0;
        end else if (en) begin
            count <= count + W'(1);
        end
    end

endmodule

`default_nettype wire

/* verif/tbds_memctl_model.sv */
// memory controller stand-in: takes the quarter-rate trigger pulse
// assumes it shares mclk and nrst with the timebase block
`timescale 1ns/10ps
`default_nettype none

module tbds_memctl_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic quarter_rate_clock,
    input wire logic quarter_rate_trigger_pulse,
    output var int event_count,
    output var int trig_offset
);
    logic clk_q;
    int since_rise;

    // ------------------------------------------------------------
    // event capture
    // ------------------------------------------------------------
    // offset is kept per event so the bench can see it does not drift
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            clk_q <= 1'b0;
            since_rise <= 0;
            event_count <= 0;
            trig_offset <= 0;
        end else begin
            clk_q <= quarter_rate_clock;
            since_rise <= (quarter_rate_clock && !clk_q) ? 0 : since_rise + 1;
            if (quarter_rate_trigger_pulse) begin
                event_count <= event_count + 1;
                trig_offset <= since_rise;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the timebase divider and trigger sync
// assumes tbds_pkg is compiled first; mclk stands in for the sample clock
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import tbds_pkg::*;
    logic mclk, nrst, system_trigger_in, digitizer_run_gate, cal_clock_enable;
    logic [3:0] digitizer_clock, quarter_rate_clock;
    logic timebase_clock, cal_quarter_rate_clock;
    tbds_trig_t trig;
    int error_cnt, n_tests, cyc, ev_cnt, ev_off;

    tbds_timebase tbds_timebase_i (.mclk(mclk), .nrst(nrst),
        .system_trigger_in(system_trigger_in),
        .digitizer_run_gate(digitizer_run_gate),
        .cal_clock_enable(cal_clock_enable),
        .digitizer_clock(digitizer_clock), .timebase_clock(timebase_clock),
        .quarter_rate_clock(quarter_rate_clock),
        .cal_quarter_rate_clock(cal_quarter_rate_clock), .trig(trig));
    tbds_memctl_model tbds_memctl_model_i (.mclk(mclk), .nrst(nrst),
        .quarter_rate_clock(quarter_rate_clock[0]),
        .quarter_rate_trigger_pulse(trig.quarter_rate_trigger_pulse),
        .event_count(ev_cnt), .trig_offset(ev_off));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= nrst ? cyc + 1 : 0;

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp,
                       input string msg);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic chk_int(input int got, input int exp, input string msg);
        n_tests++;
        if (got != exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s %0d", $time, msg, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return timebase_clock;
            5: return cal_quarter_rate_clock;
            default: return quarter_rate_clock[w-1];
        endcase
    endfunction
    // cycles until the chosen output reaches v; a hang ends the run
    task automatic wait_sig(input int w, input logic v, output int n);
        n = 0;
        while (sig(w) !== v) begin
            step(1);
            n++;
            if (n > 200) begin
                error_cnt++;
                $display("wrong value at %0t: wait timed out", $time);
                stop_test();
            end
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        int n;
        nrst = 1'b0;
        step(2);
        chk(trig, 4'h0, "trigger outputs in reset");
        chk(quarter_rate_clock, 4'h0, "quarter clocks in reset");
        nrst = 1'b1;
        step(1);
        // counters restart from zero, so the first levels are already up
        chk(timebase_clock, 1'b1, "release level");
        chk({digitizer_clock[0], trig[3:2]}, 4'h0, "release quiet");
        wait_sig(0, 1'b1, n);
        chk(quarter_rate_clock, 4'h9, "dividers share phase");
    endtask
    task automatic test_clocks();
        int n;
        wait_sig(0, 1'b0, n);
        wait_sig(0, 1'b1, n);
        chk_int(n, 5, "timebase low");
        wait_sig(0, 1'b0, n);
        chk_int(n, 5, "timebase high");
        wait_sig(1, 1'b0, n);
        wait_sig(1, 1'b1, n);
        chk_int(n, 20, "quarter low");
        for (int k = 2; k <= 4; k++) begin
            wait_sig(k, 1'b1, n);
            chk_int(n, 10, "quarter phase step");
        end
    endtask
    // gate and enable are resampled on period boundaries, hence the waits
    task automatic test_gates();
        int bad;
        bad = 0;
        digitizer_run_gate = 1'b0;
        cal_clock_enable = 1'b0;
        step(45);
        for (int i = 0; i < 40; i++) begin
            bad += int'(digitizer_clock !== 4'h0);
            bad += int'(cal_quarter_rate_clock !== 1'b0);
            step(1);
        end
        chk_int(bad, 0, "gated clocks idle");
        digitizer_run_gate = 1'b1;
        cal_clock_enable = 1'b1;
        step(45);
        for (int i = 0; i < 40; i++) begin
            bad += int'(digitizer_clock !== {4{timebase_clock}});
            bad += int'(cal_quarter_rate_clock !== quarter_rate_clock[0]);
            step(1);
        end
        chk_int(bad, 0, "gated clocks running");
        // the calibrator goes idle again: its clock must stop
        digitizer_run_gate = 1'b0;
        cal_clock_enable = 1'b0;
        step(45);
        for (int i = 0; i < 40; i++) begin
            bad += int'(digitizer_clock !== 4'h0);
            bad += int'(cal_quarter_rate_clock !== 1'b0);
            step(1);
        end
        chk_int(bad, 0, "gated clocks stopped");
    endtask
    task automatic fire(input int off, output int dtb, output int dqr,
                        output logic [1:0] code);
        int ntb, nqr, k;
        k = 0;
        while (cyc % 40 != off && k < 50) begin
            step(1);
            k++;
        end
        if (k >= 50) begin
            error_cnt++;
            $display("wrong value at %0t: launch phase timed out", $time);
            stop_test();
        end
        system_trigger_in = 1'b1;
        ntb = 0;
        nqr = 0;
        dtb = -1;
        dqr = -1;
        code = 2'h0;
        for (int i = 1; i <= 60; i++) begin
            step(1);
            if (i == 3) system_trigger_in = 1'b0;
            if (trig.timebase_trigger_pulse === 1'b1) begin
                ntb++;
                dtb = i;
                code = trig.phase_code;
            end
            nqr += int'(trig.quarter_rate_trigger_pulse === 1'b1);
            if (trig.quarter_rate_trigger_pulse === 1'b1) dqr = i;
        end
        chk_int(ntb, 1, "timebase pulses");
        chk_int(nqr, 1, "quarter pulses");
        chk_int(int'(dtb >= 3 && dtb <= 12), 1, "timebase delay");
        chk_int(int'(dqr >= 3 && dqr <= 42), 1, "quarter delay");
        chk(trig.phase_code, code, "phase code holds");
    endtask
    task automatic test_trig();
        int a1, b1, a2, b2, off1;
        logic [1:0] c1, c2;
        fire(5, a1, b1, c1);
        chk_int(a1, 5, "timebase pulse on boundary");
        chk_int(b1, 35, "quarter pulse on boundary");
        chk(c1, 2'h0, "phase code value");
        off1 = ev_off;
        fire(5, a2, b2, c2);
        chk_int(a2, a1, "timebase delay repeats");
        chk_int(b2, b1, "quarter delay repeats");
        chk_int(ev_off, off1, "controller offset repeats");
        chk(c2, c1, "phase code repeats");
        for (int j = 1; j <= 3; j++) begin
            fire(5 + 10 * j, a2, b2, c2);
            chk(c2, 2'(c1 + j), "phase code steps");
            chk_int(b2, 35 - 10 * j, "quarter pulse phase");
            chk_int(a2, 5, "timebase pulse phase");
        end
        chk_int(ev_cnt, 5, "controller events");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        error_cnt = 0;
        n_tests = 0;
        nrst = 1'b0;
        system_trigger_in = 1'b0;
        digitizer_run_gate = 1'b0;
        cal_clock_enable = 1'b0;
        step(6);
        chk(trig, 4'h0, "trigger outputs in reset");
        nrst = 1'b1;
        step(30);
        test_reset();
        test_clocks();
        test_gates();
        test_trig();
        stop_test();
    end
    initial begin
        #5000000;
        error_cnt++;
        $display("wrong value at %0t: run limit reached", $time);
        stop_test();
    end
endmodule
`default_nettype wire
